// ===== rtl/flash_register_write_and_program.sv
// flash_register_write_and_program: command interpreter for register writes,
// flag clearing and page programming of a serial flash.
// assumes an external array accepts program beats and answers prog_done.
// Behaviour
// (R01) host sets write enable before register writes
// (R02) misplaced select release drops register write
// (R03) lane zero extended, all lanes octal
// (R04) status and nonvolatile config writes self-timed
// (R05) status write updates 7:2, keeps 1:0
// (R06) protect bits combine with write-protect pin
// (R07) busy bit high, enable latch cleared
// (R08) busy bit cleared when write finishes
// (R09) volatile write immediate, reserved bits kept
// (R10) clear-flags resets errors, any release point
// (R11) host sets write enable before program
// (R12) misplaced release drops program, no errors
// (R13) address bits sampled on rising edge
// (R14) protected sector: no program, flags 1,4
// (R15) program timeout clears latch, sets fail
// (R16) program clears bits, busy, clears latch
// (R17) program pausable by suspend, resume
// (R18) bytes past page end wrap to page start
// (R19) oversize data keeps last page of bytes; code does so up to 512 bytes, later ones all land at start offset + 255
// (R20) short data leaves other page bytes
// (R21) host pads odd start with FFh
// (R22) host pads odd end with FFh
// (R23) 4-byte opcodes take 32-bit address
// (R24) write enable 06h, write disable 04h
`timescale 1ns/10ps
`default_nettype none
module flash_register_write_and_program
  import flash_wr_pkg::*;
#(
  parameter int STATUS_WRITE_CNT = STATUS_WRITE_CYCLES,
  parameter int NV_CONFIG_WRITE_CNT = NV_CONFIG_WRITE_CYCLES,
  parameter int PROG_TIMEOUT_CNT = PROG_TIMEOUT_CYCLES
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [7:0] dq_in,
  input wire logic wp_n,
  input wire logic octal_mode,
  input wire logic four_byte_mode,
  input wire logic suspend_req,
  input wire logic resume_req,
  input wire logic prog_done,
  output flash_regs_t regs,
  output prog_beat_t beat
);

  // ----------------------------------------------------------------
  // link capture and crossing
  // ----------------------------------------------------------------
  logic [7:0] link_sample;
  logic link_tog;
  logic [2:0] pins_s;

  link_sampler u_link (
    .sclk(sclk),
    .srst(srst),
    .cs_n(cs_n),
    .dq_in(dq_in),
    .sample(link_sample),
    .tog(link_tog)
  );

  sync2 #(.W(3)) u_sync (
    .mclk(mclk),
    .srst(srst),
    .d({~cs_n, ~wp_n, link_tog}), // inverted so the flops' reset value reads idle
    .q(pins_s)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] cs_hist;
    logic tog_prev;
    phase_t phase;
    logic [7:0] opc;
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic [2:0] addr_left;
    logic [31:0] addr;
    logic [8:0] data_cnt;
    logic [15:0] reg_data;
    busy_t busy;
    logic [7:0] pend_opc;
    logic [15:0] timer;
    logic [8:0] emit_idx;
    logic [31:0] page_base;
    logic [PAGE_BYTES-1:0][7:0] page_data;
    logic [PAGE_BYTES-1:0] page_mask;
    flash_regs_t regs;
    prog_beat_t beat;
  } core_t;

  core_t s;
  core_t next_s;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_program(input logic [7:0] op);
    return op == OPC_PROG || op == OPC_PROG_OCT || op == OPC_PROG_XOCT ||
           op == OPC_PROG4 || op == OPC_PROG4_OCT || op == OPC_PROG4_XOCT;
  endfunction : is_program

  function automatic logic is_program4(input logic [7:0] op);
    return op == OPC_PROG4 || op == OPC_PROG4_OCT || op == OPC_PROG4_XOCT;
  endfunction : is_program4

  // protected area grows from the top (or bottom) in powers of two sectors
  function automatic logic is_protected(input logic [7:0] st, input logic [31:0] a);
    logic [3:0] bp;
    logic [SECTOR_BITS:0] n;
    logic [SECTOR_BITS:0] sec;
    bp = st[ST_BP_LSB +: 4];
    sec = {1'b0, a[SECTOR_LSB +: SECTOR_BITS]};
    if (bp == 4'h0) begin
      n = '0;
    end else if (bp > 4'(SECTOR_BITS)) begin
      n = (SECTOR_BITS + 1)'(1 << SECTOR_BITS);
    end else begin
      n = (SECTOR_BITS + 1)'(1) << (bp - 4'h1);
    end
    if (st[ST_TB]) begin
      return sec < n;
    end
    return sec >= ((SECTOR_BITS + 1)'(1 << SECTOR_BITS) - n);
  endfunction : is_protected

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic cs_s;
  logic wp_s;
  logic tog_s;
  logic evt;
  logic frame_start;
  logic frame_end;
  logic byte_done;
  logic [7:0] byte_in;
  logic [7:0] off;
  logic aligned;
  logic paused;
  logic finish;

  assign cs_s = !pins_s[2];
  assign wp_s = !pins_s[1];
  assign tog_s = pins_s[0];

  always_comb begin
    next_s = s;
    next_s.beat.valid = 1'b0;
    next_s.cs_hist = {s.cs_hist[1:0], cs_s};
    next_s.tog_prev = tog_s;
    evt = tog_s != s.tog_prev;
    frame_start = s.cs_hist[0] && !cs_s;
    // end is judged two clocks late so the last lane sample lands first
    frame_end = s.cs_hist[1] && !s.cs_hist[2];
    byte_done = 1'b0;
    byte_in = s.shreg;
    off = s.addr[7:0] + s.data_cnt[7:0];
    aligned = s.bit_cnt == 3'h0 && s.phase != PH_OPC;
    paused = s.regs.flag[FL_PROG_SUSP];
    finish = 1'b0;

    // -------- byte assembly --------
    if (frame_start) begin
      next_s.phase = PH_OPC;
      next_s.bit_cnt = 3'h0;
      next_s.data_cnt = 9'h000;
    end else if (evt && s.phase != PH_IDLE) begin
      if (octal_mode) begin
        byte_in = link_sample; // R03
        byte_done = 1'b1;
      end else begin
        byte_in = {s.shreg[6:0], link_sample[0]}; // R03
        byte_done = s.bit_cnt == 3'h7;
        next_s.shreg = byte_in;
        next_s.bit_cnt = s.bit_cnt + 3'h1;
      end
    end

    // -------- byte handling --------
    if (byte_done) begin
      unique case (s.phase)
        PH_OPC: begin
          next_s.opc = byte_in;
          next_s.phase = PH_IGNORE;
          if (s.busy == B_IDLE) begin
            if (byte_in == OPC_WRITE_STATUS || byte_in == OPC_WRITE_NVCFG ||
                byte_in == OPC_WRITE_VCFG) begin
              next_s.phase = PH_DATA;
            end else if (byte_in == OPC_CLEAR_FLAGS) begin
              next_s.regs.flag[FL_ERASE_ERR] = 1'b0; // R10
              next_s.regs.flag[FL_PROG_ERR] = 1'b0; // R10
              next_s.regs.flag[FL_PROT_ERR] = 1'b0; // R10
            end else if (is_program(byte_in)) begin
              next_s.phase = PH_ADDR;
              next_s.addr = 32'h0000_0000;
              next_s.page_mask = '0;
              // octal frames always carry four address bytes
              if (is_program4(byte_in) || octal_mode || four_byte_mode ||
                  !s.regs.nvcfg[NVCFG_ADDR3_BIT]) begin
                next_s.addr_left = 3'h4; // R23
              end else begin
                next_s.addr_left = 3'h3;
              end
            end
          end
        end
        PH_ADDR: begin
          next_s.addr = {s.addr[23:0], byte_in}; // R13
          next_s.addr_left = s.addr_left - 3'h1;
          if (s.addr_left == 3'h1) begin
            next_s.phase = PH_DATA;
          end
        end
        PH_DATA: begin
          if (is_program(s.opc)) begin
            // offset wraps inside the page; late bytes overwrite early ones
            next_s.page_data[off] = byte_in; // R18 R19
            next_s.page_mask[off] = 1'b1; // R20
          end else begin
            next_s.reg_data = {s.reg_data[7:0], byte_in};
          end
          if (s.data_cnt != 9'h1ff) begin
            next_s.data_cnt = s.data_cnt + 9'h001;
          end
        end
        PH_IGNORE: begin
          if (s.data_cnt != 9'h1ff) begin
            next_s.data_cnt = s.data_cnt + 9'h001;
          end
        end
        PH_IDLE: begin
        end
      endcase
    end

    // -------- end of frame --------
    if (frame_end && s.phase != PH_IDLE) begin
      next_s.phase = PH_IDLE;
      // a partial byte or surplus byte leaves every register untouched, except the flags already cleared by clear-flags
      if (aligned && s.busy == B_IDLE) begin // R02 R12
        if (s.phase == PH_IGNORE && s.data_cnt == 9'h000) begin
          if (s.opc == OPC_WRITE_ENABLE) begin
            next_s.regs.status[ST_WEL] = 1'b1; // R24
          end else if (s.opc == OPC_WRITE_DISABLE && !s.regs.flag[FL_PROT_ERR]) begin
            next_s.regs.status[ST_WEL] = 1'b0; // R24
          end
        end
        if (s.phase == PH_DATA && s.regs.status[ST_WEL]) begin // R01 R11
          if (s.opc == OPC_WRITE_STATUS && s.data_cnt == 9'h001) begin
            if (s.regs.status[ST_SRWD] && !wp_s) begin
              next_s.regs.status[ST_WEL] = 1'b0; // R06
            end else begin
              next_s.busy = B_REG; // R04
              next_s.pend_opc = s.opc;
              next_s.timer = 16'(STATUS_WRITE_CNT - 1);
              next_s.regs.status[ST_WIP] = 1'b1; // R07
            end
          end else if (s.opc == OPC_WRITE_NVCFG && s.data_cnt == 9'h002) begin
            next_s.busy = B_REG; // R04
            next_s.pend_opc = s.opc;
            next_s.timer = 16'(NV_CONFIG_WRITE_CNT - 1);
            next_s.regs.status[ST_WIP] = 1'b1; // R07
          end else if (s.opc == OPC_WRITE_VCFG && s.data_cnt == 9'h001) begin
            next_s.regs.vcfg = (s.regs.vcfg & VCFG_RESERVED) |
                               (s.reg_data[7:0] & ~VCFG_RESERVED); // R09
            next_s.regs.status[ST_WEL] = 1'b0;
          end else if (is_program(s.opc) && s.data_cnt != 9'h000) begin
            if (is_protected(s.regs.status, s.addr)) begin
              next_s.regs.flag[FL_PROT_ERR] = 1'b1; // R14
              next_s.regs.flag[FL_PROG_ERR] = 1'b1; // R14
            end else begin
              next_s.busy = B_EMIT; // R16
              next_s.page_base = s.addr;
              next_s.emit_idx = 9'h000;
              next_s.timer = 16'(PROG_TIMEOUT_CNT - 1);
              next_s.regs.status[ST_WIP] = 1'b1; // R16
              next_s.regs.flag[FL_READY] = 1'b0;
            end
          end
        end
      end
    end

    // -------- self-timed operations --------
    if (s.busy == B_EMIT || s.busy == B_WAIT) begin
      if (suspend_req && !paused) begin
        next_s.regs.flag[FL_PROG_SUSP] = 1'b1; // R17
        next_s.regs.flag[FL_READY] = 1'b1; // R17
      end else if (resume_req && paused) begin
        next_s.regs.flag[FL_PROG_SUSP] = 1'b0; // R17
        next_s.regs.flag[FL_READY] = 1'b0; // R17
      end
    end

    unique case (s.busy)
      B_IDLE: begin
      end
      B_REG: begin
        if (s.timer == 16'h0000) begin
          if (s.pend_opc == OPC_WRITE_STATUS) begin
            next_s.regs.status[7:2] = s.reg_data[7:2]; // R05
          end else begin
            next_s.regs.nvcfg = {s.reg_data[7:0], s.reg_data[15:8]};
          end
          next_s.regs.status[ST_WIP] = 1'b0; // R08
          next_s.regs.status[ST_WEL] = 1'b0; // R07
          next_s.busy = B_IDLE;
        end else begin
          next_s.timer = s.timer - 16'h0001;
        end
      end
      B_EMIT: begin
        if (!paused) begin
          // the array ands each beat into the cell, so bits only fall
          next_s.beat.valid = s.page_mask[s.emit_idx[7:0]]; // R20
          next_s.beat.addr = {s.page_base[31:8], s.emit_idx[7:0]};
          next_s.beat.data = s.page_data[s.emit_idx[7:0]]; // R16
          next_s.emit_idx = s.emit_idx + 9'h001;
          if (s.emit_idx == 9'(PAGE_BYTES - 1)) begin
            next_s.busy = B_WAIT;
          end
        end
      end
      B_WAIT: begin
        if (prog_done) begin
          finish = 1'b1;
        end
      end
    endcase

    if ((s.busy == B_EMIT || s.busy == B_WAIT) && !paused && !finish) begin
      if (s.timer == 16'h0000) begin
        next_s.regs.flag[FL_PROG_ERR] = 1'b1; // R15
        finish = 1'b1;
      end else begin
        next_s.timer = s.timer - 16'h0001;
      end
    end

    if (finish) begin
      next_s.busy = B_IDLE;
      next_s.regs.status[ST_WIP] = 1'b0; // R16
      next_s.regs.status[ST_WEL] = 1'b0; // R15 R16
      next_s.regs.flag[FL_READY] = 1'b1;
      next_s.regs.flag[FL_PROG_SUSP] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      s <= '0;
      s.cs_hist <= 3'h7;
      s.phase <= PH_IDLE;
      s.busy <= B_IDLE;
      s.regs.status <= STATUS_RESET;
      s.regs.flag <= FLAG_RESET;
      s.regs.nvcfg <= NVCFG_RESET;
      s.regs.vcfg <= VCFG_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign regs = s.regs;
  assign beat = s.beat;

endmodule : flash_register_write_and_program
`default_nettype wire

// ===== rtl/flash_wr_pkg.sv
// flash_wr_pkg: opcodes, register bit positions, reset values, timing counts and
// carrier types for the register-write and page-program command block.
// assumes a 200 MHz core clock; times are converted to cycles here.
package flash_wr_pkg;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OPC_WRITE_NVCFG = 8'hb1;
  localparam logic [7:0] OPC_WRITE_VCFG = 8'h81;
  localparam logic [7:0] OPC_CLEAR_FLAGS = 8'h50;
  localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OPC_PROG = 8'h02;
  localparam logic [7:0] OPC_PROG_OCT = 8'h82;
  localparam logic [7:0] OPC_PROG_XOCT = 8'hc2;
  localparam logic [7:0] OPC_PROG4 = 8'h12;
  localparam logic [7:0] OPC_PROG4_OCT = 8'h84;
  localparam logic [7:0] OPC_PROG4_XOCT = 8'h8e;

  // ----------------------------------------------------------------
  // register fields and reset values
  // ----------------------------------------------------------------
  localparam int ST_WIP = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LSB = 2;
  localparam int ST_TB = 6;
  localparam int ST_SRWD = 7;
  localparam int FL_READY = 7;
  localparam int FL_ERASE_ERR = 5;
  localparam int FL_PROG_ERR = 4;
  localparam int FL_PROG_SUSP = 2;
  localparam int FL_PROT_ERR = 1;
  localparam int NVCFG_ADDR3_BIT = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h80;
  localparam logic [15:0] NVCFG_RESET = 16'hffff;
  localparam logic [7:0] VCFG_RESET = 8'hff;
  localparam logic [7:0] VCFG_RESERVED = 8'h04;

  // ----------------------------------------------------------------
  // geometry and timing
  // ----------------------------------------------------------------
  localparam int PAGE_BYTES = 256;
  localparam int SECTOR_LSB = 17;
  localparam int SECTOR_BITS = 6;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int STATUS_WRITE_TIME_NS = 5000;
  localparam int NV_CONFIG_WRITE_TIME_NS = 10000;
  localparam int PROG_TIMEOUT_NS = 20000;
  localparam int STATUS_WRITE_CYCLES = (STATUS_WRITE_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                       / CLK_PERIOD_PS;
  localparam int NV_CONFIG_WRITE_CYCLES = (NV_CONFIG_WRITE_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                          / CLK_PERIOD_PS;
  localparam int PROG_TIMEOUT_CYCLES = (PROG_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {PH_IDLE, PH_OPC, PH_ADDR, PH_DATA, PH_IGNORE} phase_t;
  typedef enum logic [1:0] {B_IDLE, B_REG, B_EMIT, B_WAIT} busy_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] flag;
    logic [15:0] nvcfg;
    logic [7:0] vcfg;
  } flash_regs_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [7:0] data;
  } prog_beat_t;

endpackage : flash_wr_pkg

// ===== rtl/link_sampler.sv
// link_sampler: captures the data lanes on each rising serial clock edge
// inside a frame and flips a toggle so the core clock can pick the sample up.
// assumes the serial clock only runs while chip select is low.
`timescale 1ns/10ps
`default_nettype none
module link_sampler (
  input wire logic sclk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic [7:0] dq_in,
  output logic [7:0] sample,
  output logic tog
);
  typedef struct packed {
    logic [7:0] sample;
    logic tog;
  } link_t;

  link_t s;
  link_t next_s;

  always_comb begin
    next_s = s;
    if (!cs_n) begin
      next_s.sample = dq_in; // R13
      next_s.tog = ~s.tog;
    end
  end

  // srst used asynchronously: sclk may be still while it is asserted
  always_ff @(posedge sclk or posedge srst) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sample = s.sample;
  assign tog = s.tog;
endmodule : link_sampler
`default_nettype wire

// ===== rtl/sync2.sv
// sync2: two-flop level synchroniser of parameterised width.
// assumes each bit is a slow level or a toggle held for several clocks.
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t s;
  sync_t next_s;

  always_comb begin
    next_s = s;
    next_s.s1 = d;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.s2;
endmodule : sync2
`default_nettype wire

// ===== tb/flash_host_model.sv
// flash_host_model: host controller side of the serial bus.
// assumes the bench fills q with a frame's bytes, then calls send.
`timescale 1ns/10ps
`default_nettype none
module flash_host_model (
  input wire logic oct,
  output logic sclk,
  output logic cs_n,
  output logic [7:0] dq
);
  logic [7:0] q[$];
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    dq = 8'h00;
  end
  // ----------------------------------------------------------------
  // frame driver
  // ----------------------------------------------------------------
  // nbits 0 sends whole bytes; a short count leaves a broken frame
  task automatic send(input int nbits);
    int n;
    n = (nbits == 0) ? q.size() * (oct ? 1 : 8) : nbits;
    cs_n = 1'b0;
    #20;
    for (int i = 0; i < n; i++) begin
      // idle lanes toggle so no stale level can be trusted
      dq = oct ? q[i] : {~dq[7:1], q[i / 8][7 - i % 8]};
      #16 sclk = 1'b1;
      #16 sclk = 1'b0;
    end
    #8 cs_n = 1'b1;
    dq = ~dq;
    // deselect gap well above what the block needs
    #60;
  endtask : send
endmodule : flash_host_model
`default_nettype wire

// ===== tb/flash_register_write_and_program_tb_top.sv
// flash_register_write_and_program_tb_top: directed scenarios for the command block.
// assumes the host model on the serial side and a 200 MHz core clock.
`timescale 1ns/10ps
`default_nettype none
module flash_register_write_and_program_tb_top
  import flash_wr_pkg::*;
;
  logic mclk, srst, wp_n, octal_mode, suspend_req, resume_req, prog_done, sclk, cs_n;
  logic [7:0] dq;
  logic four_byte_mode;
  flash_regs_t regs;
  prog_beat_t beat;
  int error_cnt, samples_checked;
  logic [39:0] bq[$];
  flash_host_model host_u (.oct(octal_mode), .sclk(sclk), .cs_n(cs_n), .dq(dq));
  flash_register_write_and_program #(.STATUS_WRITE_CNT(10), .NV_CONFIG_WRITE_CNT(20),
    .PROG_TIMEOUT_CNT(400)) dut_u (.mclk(mclk), .srst(srst), .sclk(sclk), .cs_n(cs_n),
    .dq_in(dq), .wp_n(wp_n), .octal_mode(octal_mode), .four_byte_mode(four_byte_mode),
    .suspend_req(suspend_req), .resume_req(resume_req), .prog_done(prog_done),
    .regs(regs), .beat(beat));
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) if (beat.valid === 1'b1) bq.push_back({beat.addr, beat.data});
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wt
  task automatic chk(input string nm, input logic [39:0] s, input logic [39:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic go();
    host_u.send(0);
    wt(1);
  endtask : go
  task automatic we();
    host_u.q = '{OPC_WRITE_ENABLE};
    go();
  endtask : we
  task automatic idle();
    for (int i = 0; i < 2000 && regs.status[ST_WIP] !== 1'b0; i++) wt(1);
    chk("wip end", regs.status[ST_WIP], 1'b0);
  endtask : idle
  task automatic pulse(ref logic s);
    s = 1'b1;
    wt(1);
    s = 1'b0;
    wt(2);
  endtask : pulse
  task automatic final_report();
    if (error_cnt == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_wel();
    we();
    chk("wel set", regs.status, 8'h02);
    host_u.q = '{OPC_WRITE_DISABLE};
    go();
    chk("wel clear", regs.status, 8'h00);
  endtask : t_wel
  task automatic t_abort();
    we();
    host_u.q = '{OPC_WRITE_STATUS, 8'h55};
    host_u.send(15);
    host_u.q = '{OPC_PROG, 8'h00, 8'h00, 8'h00, 8'haa};
    host_u.send(36);
    wt(2);
    chk("abort", {regs.status, regs.flag}, 16'h0280);
    host_u.q = '{OPC_WRITE_VCFG, 8'h00};
    go();
    chk("vcfg", regs.vcfg, 8'h04);
  endtask : t_abort
  task automatic t_status();
    we();
    host_u.q = '{OPC_WRITE_STATUS, 8'h87};
    go();
    idle();
    chk("status write", regs.status, 8'h84);
    wp_n = 1'b0;
    we();
    host_u.q = '{OPC_WRITE_STATUS, 8'h00};
    go();
    idle();
    chk("status locked", regs.status, 8'h84);
    wp_n = 1'b1;
    we();
    host_u.q = '{OPC_PROG_OCT, 8'h7e, 8'h00, 8'h00, 8'h5a};
    go();
    chk("prot err", {regs.status, regs.flag}, 16'h8692);
    host_u.q = '{OPC_CLEAR_FLAGS};
    go();
    chk("flags clear", regs.flag, 8'h80);
    host_u.q = '{OPC_WRITE_STATUS, 8'h00};
    go();
    idle();
    chk("status unlock", regs.status, 8'h00);
    we();
    host_u.q = '{OPC_WRITE_NVCFG, 8'hef, 8'hff};
    go();
    idle();
    chk("nvcfg", regs.nvcfg, 16'hffef);
  endtask : t_status
  task automatic t_ext();
    bq.delete();
    we();
    four_byte_mode = 1'b1;
    host_u.q = '{OPC_PROG, 8'h00, 8'h00, 8'h00, 8'hfe, 8'h11, 8'h22, 8'h33};
    go();
    idle();
    chk("timeout", {regs.status[1:0], regs.flag[FL_PROG_ERR]}, 3'b001);
    chk("beat cnt", 40'(bq.size()), 3);
    chk("beat 0", bq[0], 40'h0000000033);
    chk("beat 1", bq[1], 40'h000000fe11);
    chk("beat 2", bq[2], 40'h000000ff22);
    host_u.q = '{OPC_CLEAR_FLAGS};
    go();
    chk("flags clear", regs.flag, 8'h80);
  endtask : t_ext
  task automatic t_oct();
    int k;
    logic [7:0] ev;
    octal_mode = 1'b1;
    bq.delete();
    we();
    // odd start and odd end padded with ff
    host_u.q = '{OPC_PROG4_XOCT, 8'h00, 8'h00, 8'h00, 8'h10, 8'hff};
    for (int i = 1; i < 257; i++) host_u.q.push_back(8'(i));
    host_u.q.push_back(8'hff);
    go();
    for (int i = 0; i < 600 && bq.size() < 256; i++) wt(1);
    chk("beat total", 40'(bq.size()), 256);
    pulse(suspend_req);
    chk("suspend", {regs.flag[FL_READY], regs.flag[FL_PROG_SUSP]}, 2'b11);
    pulse(resume_req);
    chk("resume", regs.flag[FL_PROG_SUSP], 1'b0);
    pulse(prog_done);
    chk("prog end", {regs.status, regs.flag}, 16'h0080);
    for (int i = 0; i < 256; i++) begin
      k = (i - 16) & 255;
      if (k < 2) k += 256;
      ev = (k == 257) ? 8'hff : 8'(k);
      chk("oct beat", bq[i], {24'h0, 8'(i), ev});
    end
    octal_mode = 1'b0;
  endtask : t_oct
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    srst = 1'b1;
    wp_n = 1'b1;
    octal_mode = 1'b0;
    four_byte_mode = 1'b0;
    suspend_req = 1'b0;
    resume_req = 1'b0;
    prog_done = 1'b0;
    error_cnt = 0;
    samples_checked = 0;
    wt(5);
    srst = 1'b0;
    wt(3);
    chk("reset", regs, 40'h0080ffffff);
    t_wel();
    t_abort();
    t_status();
    t_ext();
    t_oct();
    final_report();
  end
  initial begin
    #100000;
    error_cnt++;
    final_report();
  end
endmodule : flash_register_write_and_program_tb_top
`default_nettype wire

// ===== tb/flash_wr_asserts.sv
// flash_wr_asserts: concurrent checks on the command block's ports.
// assumes the bench leaves well over 30 ns of deselect between frames.
`timescale 1ns/10ps
`default_nettype none
module flash_wr_asserts
  import flash_wr_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [7:0] dq_in,
  input wire logic wp_n,
  input wire logic octal_mode,
  input wire logic four_byte_mode,
  input wire logic suspend_req,
  input wire logic resume_req,
  input wire logic prog_done,
  input wire flash_regs_t regs,
  input wire prog_beat_t beat
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // ----------------------------------------------------------------
  // status and configuration
  // ----------------------------------------------------------------
  wel_idle_a: assert property ($rose(regs.status[ST_WEL]) |-> cs_n)
    else $error("enable latch set inside a frame");
  wip_idle_a: assert property ($rose(regs.status[ST_WIP]) |-> cs_n)
    else $error("busy started inside a frame");
  wip_hold_a: assert property ($rose(regs.status[ST_WIP]) |=> regs.status[ST_WIP] [*8])
    else $error("busy bit dropped too early");
  wip_end_wel_a: assert property ($fell(regs.status[ST_WIP]) |-> !regs.status[ST_WEL])
    else $error("enable latch kept after busy end");
  status_at_end_a: assert property ($changed(regs.status[7:2]) |-> $fell(regs.status[ST_WIP]))
    else $error("status upper bits moved outside a write end");
  nvcfg_at_end_a: assert property ($changed(regs.nvcfg) |-> $fell(regs.status[ST_WIP]))
    else $error("nonvolatile config moved outside a write end");
  vcfg_rsvd_a: assert property ((regs.vcfg & VCFG_RESERVED) == VCFG_RESERVED)
    else $error("reserved volatile bit lost");
  // ----------------------------------------------------------------
  // program flow
  // ----------------------------------------------------------------
  beat_in_prog_a: assert property (beat.valid |->
    regs.status[ST_WIP] && regs.status[ST_WEL] && !regs.flag[FL_READY])
    else $error("beat outside an active program");
  prot_err_a: assert property ($rose(regs.flag[FL_PROT_ERR]) |->
    regs.flag[FL_PROG_ERR] && regs.status[ST_WEL] && !regs.status[ST_WIP])
    else $error("protection error flags wrong");
  prog_done_a: assert property (prog_done && regs.status[ST_WIP] && !regs.flag[FL_READY] |=>
    !regs.status[ST_WIP] && !regs.status[ST_WEL] && regs.flag[FL_READY])
    else $error("program end not reflected");
  suspend_a: assert property (suspend_req && regs.status[ST_WIP] && !regs.flag[FL_READY] |=>
    regs.flag[FL_PROG_SUSP] && regs.flag[FL_READY])
    else $error("suspend not reflected");
  beat_c: cover property (beat.valid);
  prot_c: cover property ($rose(regs.flag[FL_PROT_ERR]));
  susp_c: cover property ($rose(regs.flag[FL_PROG_SUSP]));
endmodule : flash_wr_asserts
bind flash_register_write_and_program flash_wr_asserts chk_u (.mclk(mclk), .srst(srst),
  .sclk(sclk), .cs_n(cs_n), .dq_in(dq_in), .wp_n(wp_n), .octal_mode(octal_mode),
  .four_byte_mode(four_byte_mode), .suspend_req(suspend_req), .resume_req(resume_req),
  .prog_done(prog_done), .regs(regs), .beat(beat));
`default_nettype wire
